// File: inc/lccr_map.vh
`ifndef LCCR_MAP_VH
`define LCCR_MAP_VH

// register byte addresses inside the device's configuration page
`define LCCR_ADDR_LOOP_CFG 8'h01
`define LCCR_ADDR_ADDR_OFS 8'h02
`define LCCR_ADDR_SETPT0 8'h03
`define LCCR_ADDR_SETPT1 8'h04

// analog_loop_config fields
`define LCCR_SWAP_BIT 7
`define LCCR_GAIN_BIT 6
`define LCCR_REF_BIT 5
`define LCCR_RFB_HI 4
`define LCCR_RFB_LO 2
`define LCCR_DRIVE_BIT 1
`define LCCR_SHUTDOWN_POLARITY_BIT 0

// bus_address_and_table_offset fields
`define LCCR_SADDR_HI 7
`define LCCR_SADDR_LO 4
`define LCCR_TOFS_HI 3
`define LCCR_TOFS_LO 0

// factory contents of the non-volatile cells
`define LCCR_LOOP_CFG_INIT 8'h00
`define LCCR_ADDR_OFS_INIT 8'ha0
`define LCCR_SETPT_INIT 8'h00

// setpoint selection codes
`define LCCR_SEL_ZERO 2'h0
`define LCCR_SEL_ONE 2'h1
`define LCCR_SEL_TWO 2'h2

// resistor switch count: codes 1..7 each close one switch
`define LCCR_RFB_TAPS 7

`endif

// File: core/lccr_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "lccr_map.vh"

// Contract
// - a write to analog_loop_config aborts the running conversion, discarding its result.
// - once that write completes, a fresh conversion sequence is started.
// - analog_loop_config keeps all bits through power and reset cycles.
// - register access is granted only while a valid OEM password stands.
// - bit 7 swaps op-amp inputs: 0 emitter follower, 1 common emitter.
// - bit 6 at 1 gives quarter-reference full scale, at 0 full reference.
// - bit 5 references feedback and termination to supply at 1, ground at 0.
// - bits 4..2 pick feedback resistor: 000 open, then 800 ohm doubling to 51.2k.
// - bit 1 at 1 gives source drive (NPN), at 0 sink drive (PNP).
// - bit 0 sets shutdown output active level: 1 high, 0 low.
// - high four slave address bits default 1010 and act at once.
// - table offset adds to temperature for the index, acting only after reset.
// - select 00 uses setpoint zero, 01 uses setpoint one.
// - loop on: selected setpoint plus signed table value goes to the bias DAC.
// - loop off: selected setpoint goes straight to the bias DAC.
// - the code applied to the bias DAC is readable back in both states.
// - polarity config decides whether larger codes raise or lower the DAC output.
// - setpoints and second config register are non-volatile, setpoints default 00.
// - the two-bit select field from user control chooses the setpoint source.
module lccr_regs (
	input wire mclk_in,
	input wire arst_n_in,
	// register port from the serial bus engine, same clock
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wdata_in,
	input wire oem_password_ok_in,
	output reg [7:0] reg_rdata_out,
	output reg reg_hit_out,
	// converter sequencing
	output reg adc_abort_out,
	output reg adc_start_out,
	// loop configuration outputs
	output wire opamp_input_swap_out,
	output wire full_scale_quarter_out,
	output wire feedback_reference_select_out,
	output wire [2:0] feedback_resistor_code_out,
	output wire [`LCCR_RFB_TAPS-1:0] feedback_switch_out,
	output wire feedback_open_out,
	output wire drive_type_select_out,
	input wire shutdown_request_in,
	output reg shutdown_output_out,
	// serial address and table indexing
	output wire [3:0] slave_address_high_bits_out,
	input wire [7:0] temperature_in,
	output reg [7:0] table_index_out,
	output reg [3:0] table_index_offset_out,
	// bias DAC path
	input wire power_loop_on_in,
	input wire [1:0] setpoint_select_in,
	input wire [7:0] power_setpoint_two_in,
	input wire [7:0] table_value_in,
	input wire dac_polarity_config_in,
	output reg [7:0] selected_power_setpoint_out,
	output reg [7:0] setpoint_dac_out,
	output reg [7:0] bias_dac_readback_out
);

	reg rst_sync_a;
	reg rst_sync_b;
	wire rst_n;

	// the non-volatile cells: no reset touches them, they model the
	// array contents that survive power and reset cycles
	reg [7:0] analog_loop_config;
	reg [7:0] bus_address_and_table_offset;
	reg [7:0] power_setpoint_zero;
	reg [7:0] power_setpoint_one;

	reg offset_pending;
	reg restart_pending;

	wire wr_ok;
	wire rd_ok;
	wire hit;
	reg [7:0] next_rdata;

	reg [7:0] next_selected;
	reg signed [9:0] loop_sum;
	reg [7:0] next_dac_code;
	reg [7:0] loop_code;

	// factory contents; an erase or programming pass outside writes them
	initial begin
		analog_loop_config = `LCCR_LOOP_CFG_INIT;
		bus_address_and_table_offset = `LCCR_ADDR_OFS_INIT;
		power_setpoint_zero = `LCCR_SETPT_INIT;
		power_setpoint_one = `LCCR_SETPT_INIT;
	end

	always @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_sync_a <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_sync_a <= 1'b1;
			rst_sync_b <= rst_sync_a;
		end
	end

	assign rst_n = rst_sync_b;

	assign hit = (reg_addr_in == `LCCR_ADDR_LOOP_CFG) ||
		(reg_addr_in == `LCCR_ADDR_ADDR_OFS) ||
		(reg_addr_in == `LCCR_ADDR_SETPT0) ||
		(reg_addr_in == `LCCR_ADDR_SETPT1);

	// without a valid password nothing is stored and no restart begins
	assign wr_ok = reg_wr_in && hit && oem_password_ok_in;
	assign rd_ok = reg_rd_in && hit && oem_password_ok_in;

	// stored writes; reset leaves these cells alone
	always @(posedge mclk_in) begin
		if (wr_ok) begin
			case (reg_addr_in)
			`LCCR_ADDR_LOOP_CFG: begin
				analog_loop_config <= reg_wdata_in;
			end
			`LCCR_ADDR_ADDR_OFS: begin
				bus_address_and_table_offset <= reg_wdata_in;
			end
			`LCCR_ADDR_SETPT0: begin
				power_setpoint_zero <= reg_wdata_in;
			end
			`LCCR_ADDR_SETPT1: begin
				power_setpoint_one <= reg_wdata_in;
			end
			default: begin
			end
			endcase
		end
	end

	// read data; a refused read answers zero so nothing leaks
	always @* begin
		next_rdata = 8'h00;
		if (rd_ok) begin
			case (reg_addr_in)
			`LCCR_ADDR_LOOP_CFG: next_rdata = analog_loop_config;
			`LCCR_ADDR_ADDR_OFS: next_rdata = bus_address_and_table_offset;
			`LCCR_ADDR_SETPT0: next_rdata = power_setpoint_zero;
			`LCCR_ADDR_SETPT1: next_rdata = power_setpoint_one;
			default: next_rdata = 8'h00;
			endcase
		end
	end

	always @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_out <= 8'h00;
			reg_hit_out <= 1'b0;
		end else begin
			reg_rdata_out <= next_rdata;
			reg_hit_out <= rd_ok | wr_ok;
		end
	end

	// abort in the write cycle's next edge, restart one cycle later when the
	// write has landed, so the new settings are in place for the fresh sample
	always @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			adc_abort_out <= 1'b0;
			adc_start_out <= 1'b0;
			restart_pending <= 1'b0;
		end else begin
			adc_abort_out <= wr_ok && (reg_addr_in == `LCCR_ADDR_LOOP_CFG);
			restart_pending <= wr_ok && (reg_addr_in == `LCCR_ADDR_LOOP_CFG);
			adc_start_out <= restart_pending;
		end
	end

	assign opamp_input_swap_out = analog_loop_config[`LCCR_SWAP_BIT];
	assign full_scale_quarter_out = analog_loop_config[`LCCR_GAIN_BIT];
	assign feedback_reference_select_out = analog_loop_config[`LCCR_REF_BIT];
	assign feedback_resistor_code_out =
		analog_loop_config[`LCCR_RFB_HI:`LCCR_RFB_LO];
	assign feedback_open_out = (feedback_resistor_code_out == 3'h0);
	assign drive_type_select_out = analog_loop_config[`LCCR_DRIVE_BIT];

	// one switch per resistor tap: code n closes tap n-1 (800 ohm << (n-1))
	genvar tap;
	generate
		for (tap = 0; tap < `LCCR_RFB_TAPS; tap = tap + 1) begin : g_tap
			assign feedback_switch_out[tap] =
				(feedback_resistor_code_out == (tap + 1));
		end
	endgenerate

	// shutdown pin level follows the chosen active polarity
	always @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			shutdown_output_out <= 1'b0;
		end else begin
			shutdown_output_out <= shutdown_request_in ~^
				analog_loop_config[`LCCR_SHUTDOWN_POLARITY_BIT];
		end
	end

	// the address bits act straight from the cell, no shadow copy
	assign slave_address_high_bits_out =
		bus_address_and_table_offset[`LCCR_SADDR_HI:`LCCR_SADDR_LO];

	// the offset is copied once after each reset release; later writes sit
	// in the cell until the next reset
	always @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			offset_pending <= 1'b1;
			table_index_offset_out <= 4'h0;
		end else if (offset_pending) begin
			offset_pending <= 1'b0;
			table_index_offset_out <=
				bus_address_and_table_offset[`LCCR_TOFS_HI:`LCCR_TOFS_LO];
		end
	end

	always @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			table_index_out <= 8'h00;
		end else begin
			// index wraps at 8 bits; the table outside has 256 entries
			table_index_out <= temperature_in + {4'h0, table_index_offset_out};
		end
	end

	// setpoint choice; the reserved code falls back to setpoint zero
	always @* begin
		case (setpoint_select_in)
		`LCCR_SEL_ZERO: next_selected = power_setpoint_zero;
		`LCCR_SEL_ONE: next_selected = power_setpoint_one;
		`LCCR_SEL_TWO: next_selected = power_setpoint_two_in;
		default: next_selected = power_setpoint_zero;
		endcase
	end

	// saturate the sum so a large table value cannot wrap the bias around
	always @* begin
		loop_sum = $signed({2'b00, next_selected}) +
			$signed({{2{table_value_in[7]}}, table_value_in});
		if (loop_sum < 10'sd0) begin
			loop_code = 8'h00;
		end else if (loop_sum > 10'sd255) begin
			loop_code = 8'hff;
		end else begin
			loop_code = loop_sum[7:0];
		end
		if (power_loop_on_in) begin
			next_dac_code = loop_code;
		end else begin
			next_dac_code = next_selected;
		end
	end

	always @(posedge mclk_in or negedge rst_n) begin
		if (!rst_n) begin
			selected_power_setpoint_out <= 8'h00;
			setpoint_dac_out <= 8'h00;
			bias_dac_readback_out <= 8'h00;
		end else begin
			selected_power_setpoint_out <= next_selected;
			// polarity set means larger numbers lower the output
			setpoint_dac_out <= dac_polarity_config_in ?
				~next_dac_code : next_dac_code;
			bias_dac_readback_out <= next_dac_code;
		end
	end

endmodule
`default_nettype wire

// File: verification/lccr_properties.sv
`timescale 1ns/100ps
`default_nettype none
module lccr_properties (
	input wire logic mclk_in,
	input wire logic arst_n_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic oem_password_ok_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_hit_out,
	input wire logic adc_abort_out,
	input wire logic adc_start_out,
	input wire logic [2:0] feedback_resistor_code_out,
	input wire logic [6:0] feedback_switch_out,
	input wire logic feedback_open_out,
	input wire logic [3:0] slave_address_high_bits_out,
	input wire logic power_loop_on_in,
	input wire logic [1:0] setpoint_select_in,
	input wire logic [7:0] power_setpoint_two_in,
	input wire logic dac_polarity_config_in,
	input wire logic [7:0] setpoint_dac_out,
	input wire logic [7:0] bias_dac_readback_out
);
	logic [2:0] up;
	logic w2;
	// internal reset trails the pin by two flops, so checks wait three edges
	always_ff @(posedge mclk_in or negedge arst_n_in)
		if (!arst_n_in)
			up <= 3'h0;
		else
			up <= {up[1:0], 1'b1};
	always_ff @(posedge mclk_in)
		w2 <= reg_wr_in && oem_password_ok_in && reg_addr_in == 8'h02;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!up[2]);
	property p_abort;
		reg_wr_in && oem_password_ok_in && reg_addr_in == 8'h01 |=> adc_abort_out;
	endproperty
	a_abort: assert property (p_abort) else $error("no abort after config write");
	property p_start;
		adc_abort_out |=> adc_start_out;
	endproperty
	a_start: assert property (p_start) else $error("no restart after abort");
	property p_refuse;
		reg_wr_in && !oem_password_ok_in |=> !reg_hit_out && !adc_abort_out;
	endproperty
	a_refuse: assert property (p_refuse) else $error("write taken without password");
	property p_unmap;
		reg_rd_in && reg_addr_in > 8'h04 |=> reg_rdata_out == 8'h00 && !reg_hit_out;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read answered");
	property p_open;
		feedback_open_out == (feedback_resistor_code_out == 3'h0);
	endproperty
	a_open: assert property (p_open) else $error("open flag wrong");
	property p_switch;
		feedback_switch_out == (feedback_resistor_code_out == 3'h0 ? 7'h00 :
			7'h01 << (feedback_resistor_code_out - 3'h1));
	endproperty
	a_switch: assert property (p_switch) else $error("resistor switch wrong");
	property p_saddr;
		$changed(slave_address_high_bits_out) |-> w2;
	endproperty
	a_saddr: assert property (p_saddr) else $error("address bits moved alone");
	property p_off;
		!power_loop_on_in && setpoint_select_in == 2'h2 |=>
			bias_dac_readback_out == $past(power_setpoint_two_in);
	endproperty
	a_off: assert property (p_off) else $error("loop off code wrong");
	property p_pol;
		1'b1 |=> setpoint_dac_out == ($past(dac_polarity_config_in) ?
			~bias_dac_readback_out : bias_dac_readback_out);
	endproperty
	a_pol: assert property (p_pol) else $error("dac polarity wrong");
	c_restart: cover property (adc_start_out);
	c_refused: cover property (reg_wr_in && !oem_password_ok_in);
	c_third: cover property (setpoint_select_in == 2'h2 && !power_loop_on_in);
endmodule
`default_nettype wire

// File: verification/lccr_host.sv
`timescale 1ns/100ps
`default_nettype none
module lccr_host (
	input wire logic mclk_in,
	input wire logic [7:0] reg_rdata_in,
	input wire logic reg_hit_in,
	output logic reg_wr_out = 0,
	output logic reg_rd_out = 0,
	output logic [7:0] reg_addr_out = 0,
	output logic [7:0] reg_wdata_out = 0,
	output logic oem_password_ok_out = 0
);
	// one fixed serial address stands for every access, so a new address needs no re-aim here
	task pw(input v);
		@(posedge mclk_in) oem_password_ok_out <= v;
	endtask
	// one strobe per byte; released lines show the inverse so stale values never match
	task xfer(input w, input [7:0] a, input [7:0] d, output [7:0] q, output h);
		@(posedge mclk_in);
		reg_wr_out <= w;
		reg_rd_out <= !w;
		reg_addr_out <= a;
		reg_wdata_out <= d;
		@(posedge mclk_in);
		reg_wr_out <= 0;
		reg_rd_out <= 0;
		reg_addr_out <= ~a;
		reg_wdata_out <= ~d;
		#1;
		q = reg_rdata_in;
		h = reg_hit_in;
	endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic mclk_in = 0;
	logic arst_n_in = 0;
	logic shutdown_request_in = 0;
	logic power_loop_on_in = 0;
	logic dac_polarity_config_in = 0;
	logic [1:0] setpoint_select_in = 0;
	logic [7:0] temperature_in = 0;
	logic [7:0] power_setpoint_two_in = 8'h5a;
	logic [7:0] table_value_in = 0;
	wire reg_wr_in, reg_rd_in, oem_password_ok_in, reg_hit_out, adc_abort_out, adc_start_out;
	wire opamp_input_swap_out, full_scale_quarter_out, feedback_reference_select_out;
	wire feedback_open_out, drive_type_select_out, shutdown_output_out;
	wire [2:0] feedback_resistor_code_out;
	wire [6:0] feedback_switch_out;
	wire [3:0] slave_address_high_bits_out, table_index_offset_out;
	wire [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, table_index_out;
	wire [7:0] selected_power_setpoint_out, setpoint_dac_out, bias_dac_readback_out;
	wire [7:0] cfg_bits = {opamp_input_swap_out, full_scale_quarter_out,
		feedback_reference_select_out, feedback_resistor_code_out, drive_type_select_out,
		shutdown_output_out};
	int fails = 0;
	int tests_run = 0;
	lccr_regs lccr_regs_inst (.*);
	lccr_host lccr_host_inst (.mclk_in(mclk_in), .reg_rdata_in(reg_rdata_out),
		.reg_hit_in(reg_hit_out), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
		.reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
		.oem_password_ok_out(oem_password_ok_in));
	initial forever #4 mclk_in = ~mclk_in;
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task ck(input [7:0] g, input [7:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask
	task ac(input w, input [7:0] a, input [7:0] d, input [7:0] eq, input eh);
		logic [7:0] q;
		logic h;
		lccr_host_inst.xfer(w, a, d, q, h);
		ck(q, eq);
		ck(h, eh);
	endtask
	task bs(input l, input [1:0] s, input [7:0] t, input p, input [7:0] e);
		@(posedge mclk_in);
		power_loop_on_in <= l;
		setpoint_select_in <= s;
		table_value_in <= t;
		dac_polarity_config_in <= p;
		@(posedge mclk_in) #1;
		ck(bias_dac_readback_out, e);
		if (!l) ck(selected_power_setpoint_out, e);
		ck(setpoint_dac_out, p ? ~e : e);
	endtask
	task rst;
		@(posedge mclk_in) arst_n_in <= 0;
		repeat (2) @(posedge mclk_in);
		arst_n_in <= 1;
		repeat (4) @(posedge mclk_in);
		#1;
	endtask
	task t_defaults;
		ac(0, 8'h01, 8'h00, 8'h00, 1);
		ac(0, 8'h02, 8'h00, 8'ha0, 1);
		ac(0, 8'h03, 8'h00, 8'h00, 1);
		ac(0, 8'h04, 8'h00, 8'h00, 1);
		ac(0, 8'h05, 8'h00, 8'h00, 0);
	endtask
	task t_cfg;
		@(posedge mclk_in) shutdown_request_in <= 1;
		for (int i = 0; i < 8; i++) begin
			ac(1, 8'h01, {3'h2, i[2:0], 1'b0, i[0]}, 8'h00, 1);
			ck(feedback_switch_out, i ? 7'h01 << (i - 1) : 7'h00);
			ck(feedback_open_out, i == 0);
			@(posedge mclk_in) #1;
			ck(shutdown_output_out, i[0]);
		end
		ac(1, 8'h01, 8'he3, 8'h00, 1);
		ck(adc_abort_out, 1);
		ck(adc_start_out, 0);
		@(posedge mclk_in) #1;
		ck(adc_abort_out, 0);
		ck(adc_start_out, 1);
		ck(cfg_bits, 8'he3);
	endtask
	task t_refuse;
		lccr_host_inst.pw(0);
		ac(1, 8'h01, 8'h00, 8'h00, 0);
		ac(0, 8'h01, 8'h00, 8'h00, 0);
		lccr_host_inst.pw(1);
		ac(0, 8'h01, 8'h00, 8'he3, 1);
	endtask
	task t_addr;
		@(posedge mclk_in) temperature_in <= 8'hf8;
		ac(1, 8'h02, 8'h5c, 8'h00, 1);
		ck(slave_address_high_bits_out, 4'h5);
		ck(table_index_offset_out, 4'h0);
		rst();
		ck(table_index_offset_out, 4'hc);
		ck(table_index_out, 8'h04);
		ac(0, 8'h01, 8'h00, 8'he3, 1);
		ac(0, 8'h02, 8'h00, 8'h5c, 1);
	endtask
	task t_bias;
		ac(1, 8'h03, 8'hf0, 8'h00, 1);
		ac(1, 8'h04, 8'h10, 8'h00, 1);
		bs(0, 2'h0, 8'h20, 0, 8'hf0);
		bs(0, 2'h1, 8'h20, 0, 8'h10);
		bs(0, 2'h2, 8'h20, 0, 8'h5a);
		bs(1, 2'h0, 8'h20, 0, 8'hff);
		bs(1, 2'h1, 8'he0, 0, 8'h00);
		bs(1, 2'h1, 8'h05, 1, 8'h15);
	endtask
	initial begin
		repeat (20) @(posedge mclk_in);
		arst_n_in <= 1;
		repeat (4) @(posedge mclk_in);
		lccr_host_inst.pw(1);
		t_defaults();
		t_cfg();
		t_refuse();
		t_addr();
		t_bias();
		give_verdict();
	end
	initial begin
		#100000;
		fails++;
		give_verdict();
	end
endmodule
bind lccr_regs lccr_properties lccr_properties_inst (.*);
`default_nettype wire
